// *** include/mdg_pkg.sv ***
package mdg_pkg;

    // ------------------------------------------------------------------
    // Pin layout: low-power port, peripheral port, fast port
    // ------------------------------------------------------------------
    localparam int          N_PINS       = 31;
    localparam int          P1_FIRST     = 5;
    localparam int          P2_FIRST     = 20;
    localparam logic [30:0] FAST_MASK    = 31'h7ff00000;
    localparam logic [30:0] SENSE_MASK   = 31'h000fffff;
    localparam logic [30:0] ANALOG_MASK  = 31'h000b0e60;
    localparam logic [30:0] SPECIAL_MASK = 31'h000021e0;
    localparam logic [30:0] XTAL_MASK    = 31'h00000060;
    localparam logic [30:0] ANT_MASK     = 31'h00000180;
    localparam logic [30:0] REF_MASK     = 31'h00002000;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [11:0] CFG_BASE   = 12'h000;
    localparam logic [11:0] OUT_OFS    = 12'h080;
    localparam logic [11:0] OUTSET_OFS = 12'h084;
    localparam logic [11:0] OUTCLR_OFS = 12'h088;
    localparam logic [11:0] IN_OFS     = 12'h08c;
    localparam logic [11:0] EVT_OFS    = 12'h090;
    localparam logic [11:0] EVTCLR_OFS = 12'h094;
    localparam logic [11:0] INTEN_OFS  = 12'h098;
    localparam logic [11:0] TASK_OFS   = 12'h09c;

    // ------------------------------------------------------------------
    // Pin configuration word fields
    // ------------------------------------------------------------------
    localparam int CFG_DIR   = 0;
    localparam int CFG_DISC  = 1;
    localparam int CFG_PULL  = 2;
    localparam int CFG_OD    = 4;
    localparam int CFG_HD    = 5;
    localparam int CFG_SENSE = 8;
    localparam int CFG_TASK  = 12;
    localparam int CFG_FUNC  = 16;

    localparam logic [2:0] FUNC_GPIO    = 3'h0;
    localparam logic [2:0] FUNC_PERIPH  = 3'h1;
    localparam logic [2:0] FUNC_XDOM    = 3'h2;
    localparam logic [2:0] FUNC_ANALOG  = 3'h3;
    localparam logic [2:0] FUNC_SPECIAL = 3'h4;

    localparam logic [1:0] PULL_DOWN = 2'h1;
    localparam logic [1:0] PULL_UP   = 2'h3;
    localparam logic [1:0] TASK_SET  = 2'h1;
    localparam logic [1:0] TASK_CLR  = 2'h2;
    localparam logic [1:0] TASK_TGL  = 2'h3;

    typedef struct packed {
        logic [2:0] func;
        logic [1:0] task_mode;
        logic [1:0] sense;
        logic       hd;
        logic       od;
        logic [1:0] pull;
        logic       disc;
        logic       dir;
    } mdg_cfg_s;

    localparam mdg_cfg_s CFG_RESET     = '{func: FUNC_GPIO, disc: 1'b1, default: '0};
    localparam mdg_cfg_s CFG_ANT_RESET = '{func: FUNC_SPECIAL, disc: 1'b1, default: '0};

    typedef struct packed {
        logic [30:0] o;
        logic [30:0] oe;
        logic [30:0] ie;
        logic [30:0] pu;
        logic [30:0] pd;
        logic [30:0] hd;
    } mdg_pad_s;

endpackage : mdg_pkg

// *** design/mdg_gpio.sv ***
// Contract
// - After reset all pins but the two antenna pins are plain I/O with no function attached.
// - Analog function selection is refused on the 23 non-analog pins.
// - Low-power port has wake, edge sense and task/event hooks.
// - Peripheral port has wake, edge sense and task/event hooks.
// - Fast port has no wake, no sense and no task/event hooks.
// - High-drive mode exists only on fast port pins.
// - Crystal pins reset as I/O, connect to crystal only when configured.
// - Antenna pins reset to antenna function, become I/O only when configured.
// - Reference pin resets as I/O, feeds converter reference only when configured.
// - Output pins select push-pull or open-drain; open-drain only pulls low.
// - Input pins select no pull, pull-up or pull-down.
// - Input edges detected as configured raise an event, and an interrupt where enabled in the interrupt enable register.
// - Disconnected pin has input and output buffers both off.
// - Pins set, clear or toggle on events without processor action.
// - Peripheral signals reach only pins of their own domain, except cross-domain functions on fast port pins.
// - Only fast port shared pins may take cross-domain serial functions.
`timescale 1ns/1ps
`default_nettype none
module mdg_gpio #(
    parameter int N_PINS = mdg_pkg::N_PINS
) (
    input  wire logic              hclk,
    input  wire logic              hresetn,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic                   hreadyout,
    output logic [31:0]            hrdata,
    output logic                   hresp,
    input  wire logic [30:0]       pin_i,
    output mdg_pkg::mdg_pad_s      pad,
    input  wire logic [30:0]       periph_own_o,
    input  wire logic [30:0]       periph_own_oe,
    input  wire logic [30:0]       periph_xdom_o,
    input  wire logic [30:0]       periph_xdom_oe,
    input  wire logic [30:0]       task_trig,
    output logic [30:0]            periph_in,
    output logic [30:0]            pin_event,
    output logic [30:0]            analog_connect,
    output logic                   lf_xtal_connect,
    output logic                   antenna_connect,
    output logic                   converter_ref_connect,
    output logic                   wake_req,
    output logic                   irq
);

    if (N_PINS != 31) begin : g_bad_pins
        $error("mdg_gpio: pin map is fixed at 31 pins");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        mdg_pkg::mdg_cfg_s [30:0] cfg;
        logic [30:0]              outv;
        logic [30:0]              sync1;
        logic [30:0]              sync2;
        logic [30:0]              prev;
        logic [30:0]              evt;
        logic [30:0]              inten;
        mdg_pkg::mdg_pad_s        pad;
        logic [30:0]              periph_in;
        logic [30:0]              pin_event;
        logic [30:0]              analog;
        logic                     xtal;
        logic                     ant;
        logic                     vref;
        logic                     wake;
        logic                     irq;
        logic                     rd_pend;
        logic                     wr_pend;
        logic [11:0]              ap_addr;
        logic [31:0]              hrdata;
        logic                     hreadyout;
        logic                     hresp;
    } mdg_state_s;

    mdg_state_s st;
    mdg_state_s next_st;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function automatic logic [31:0] cfg_to_word(input mdg_pkg::mdg_cfg_s c);
        logic [31:0] w;
        w = '0;
        w[mdg_pkg::CFG_DIR]                  = c.dir;
        w[mdg_pkg::CFG_DISC]                 = c.disc;
        w[mdg_pkg::CFG_PULL +: 2]            = c.pull;
        w[mdg_pkg::CFG_OD]                   = c.od;
        w[mdg_pkg::CFG_HD]                   = c.hd;
        w[mdg_pkg::CFG_SENSE +: 2]           = c.sense;
        w[mdg_pkg::CFG_TASK +: 2]            = c.task_mode;
        w[mdg_pkg::CFG_FUNC +: 3]            = c.func;
        return w;
    endfunction : cfg_to_word

    // Illegal field values are dropped so the pin keeps a legal setting
    function automatic mdg_pkg::mdg_cfg_s cfg_fix(input logic [4:0] idx, input logic [31:0] w,
                                                  input mdg_pkg::mdg_cfg_s old);
        mdg_pkg::mdg_cfg_s c;
        logic              fast;
        logic [2:0]        f;
        fast        = mdg_pkg::FAST_MASK[idx];
        f           = w[mdg_pkg::CFG_FUNC +: 3];
        c.dir       = w[mdg_pkg::CFG_DIR];
        c.disc      = w[mdg_pkg::CFG_DISC];
        c.pull      = w[mdg_pkg::CFG_PULL +: 2];
        c.od        = w[mdg_pkg::CFG_OD];
        c.hd        = w[mdg_pkg::CFG_HD] & fast;
        c.sense     = fast ? 2'h0 : w[mdg_pkg::CFG_SENSE +: 2];
        c.task_mode = fast ? 2'h0 : w[mdg_pkg::CFG_TASK +: 2];
        c.func      = f;
        if (f == mdg_pkg::FUNC_ANALOG && !mdg_pkg::ANALOG_MASK[idx]) begin
            c.func = old.func;
        end else if (f == mdg_pkg::FUNC_SPECIAL && !mdg_pkg::SPECIAL_MASK[idx]) begin
            c.func = old.func;
        end else if (f == mdg_pkg::FUNC_XDOM && !fast) begin
            c.func = old.func;
        end else if (f > mdg_pkg::FUNC_SPECIAL) begin
            c.func = old.func;
        end
        return c;
    endfunction : cfg_fix

    // ------------------------------------------------------------------
    // Per-pin pad logic
    // ------------------------------------------------------------------
    mdg_pkg::mdg_pad_s pad_c;
    logic [30:0]       edge_hit;
    logic [30:0]       set_m;
    logic [30:0]       clr_m;
    logic [30:0]       tgl_m;
    logic [30:0]       func_analog_m;
    logic [30:0]       func_xdom_m;
    logic [30:0]       func_special_m;
    logic [30:0]       func_own_m;
    logic [30:0]       disc_m;
    logic [30:0]       od_out_m;

    for (genvar i = 0; i < 31; i++) begin : g_pin
        mdg_pkg::mdg_cfg_s c;
        logic              gpio_f;
        logic              per_f;
        logic              src_o;
        logic              src_oe;
        assign c      = st.cfg[i];
        assign gpio_f = (c.func == mdg_pkg::FUNC_GPIO);
        // Peripherals only reach pins of their own domain; cross routes are fast-port only
        assign per_f  = (c.func == mdg_pkg::FUNC_PERIPH) || (c.func == mdg_pkg::FUNC_XDOM);
        assign src_o  = gpio_f ? st.outv[i] :
                        (c.func == mdg_pkg::FUNC_XDOM) ? periph_xdom_o[i] : periph_own_o[i];
        assign src_oe = gpio_f ? c.dir :
                        (c.func == mdg_pkg::FUNC_XDOM) ? periph_xdom_oe[i] : periph_own_oe[i];
        // Open drain never drives high: it releases instead
        assign pad_c.o[i]  = src_o & ~c.od;
        assign pad_c.oe[i] = (gpio_f | per_f) & ~c.disc & src_oe & ~(c.od & src_o);
        assign pad_c.ie[i] = (gpio_f | per_f) & ~c.disc;
        assign pad_c.pu[i] = pad_c.ie[i] & (c.pull == mdg_pkg::PULL_UP);
        assign pad_c.pd[i] = pad_c.ie[i] & (c.pull == mdg_pkg::PULL_DOWN);
        assign pad_c.hd[i] = c.hd & pad_c.oe[i];
        assign edge_hit[i] = mdg_pkg::SENSE_MASK[i] & gpio_f & ~c.disc &
                             ((c.sense[0] & st.sync2[i] & ~st.prev[i]) |
                              (c.sense[1] & ~st.sync2[i] & st.prev[i]));
        assign set_m[i]          = (c.task_mode == mdg_pkg::TASK_SET);
        assign clr_m[i]          = (c.task_mode == mdg_pkg::TASK_CLR);
        assign tgl_m[i]          = (c.task_mode == mdg_pkg::TASK_TGL);
        assign func_analog_m[i]  = (c.func == mdg_pkg::FUNC_ANALOG);
        assign func_xdom_m[i]    = (c.func == mdg_pkg::FUNC_XDOM);
        assign func_special_m[i] = (c.func == mdg_pkg::FUNC_SPECIAL);
        assign func_own_m[i]     = (c.func == mdg_pkg::FUNC_PERIPH);
        assign disc_m[i]         = c.disc;
        assign od_out_m[i]       = c.od;
    end

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    logic        take;
    logic [4:0]  wr_idx;
    logic [31:0] rdw;
    logic [30:0] sw_task;
    logic [30:0] evt_clr;
    logic [30:0] trig;

    always_comb begin
        next_st = st;
        take    = hsel & hready & htrans[1];
        wr_idx  = st.ap_addr[6:2];
        sw_task = '0;
        evt_clr = '0;
        rdw     = '0;

        next_st.sync1 = pin_i;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;

        // Writes complete with no wait; reads take one wait state so hrdata leaves a flop
        next_st.wr_pend = take & hwrite;
        if (take) begin
            next_st.ap_addr = haddr[11:0];
        end
        if (take & ~hwrite) begin
            next_st.rd_pend   = 1'b1;
            next_st.hreadyout = 1'b0;
        end
        if (st.rd_pend) begin
            if (st.ap_addr[11:7] == 5'h0 && st.ap_addr[6:2] != 5'h1f) begin
                rdw = cfg_to_word(st.cfg[st.ap_addr[6:2]]);
            end else if (st.ap_addr == mdg_pkg::OUT_OFS) begin
                rdw = {1'b0, st.outv};
            end else if (st.ap_addr == mdg_pkg::IN_OFS) begin
                rdw = {1'b0, st.sync2};
            end else if (st.ap_addr == mdg_pkg::EVT_OFS) begin
                rdw = {1'b0, st.evt};
            end else if (st.ap_addr == mdg_pkg::INTEN_OFS) begin
                rdw = {1'b0, st.inten};
            end
            next_st.hrdata    = rdw;
            next_st.hreadyout = 1'b1;
            next_st.rd_pend   = 1'b0;
        end

        if (st.wr_pend) begin
            if (st.ap_addr[11:7] == 5'h0 && wr_idx != 5'h1f) begin
                next_st.cfg[wr_idx] = cfg_fix(wr_idx, hwdata, st.cfg[wr_idx]);
            end else if (st.ap_addr == mdg_pkg::OUT_OFS) begin
                next_st.outv = hwdata[30:0];
            end else if (st.ap_addr == mdg_pkg::OUTSET_OFS) begin
                next_st.outv = st.outv | hwdata[30:0];
            end else if (st.ap_addr == mdg_pkg::OUTCLR_OFS) begin
                next_st.outv = st.outv & ~hwdata[30:0];
            end else if (st.ap_addr == mdg_pkg::EVTCLR_OFS) begin
                evt_clr = hwdata[30:0];
            end else if (st.ap_addr == mdg_pkg::INTEN_OFS) begin
                next_st.inten = hwdata[30:0];
            end else if (st.ap_addr == mdg_pkg::TASK_OFS) begin
                sw_task = hwdata[30:0];
            end
        end

        // Event-driven output changes; they win over a software write in the same cycle
        trig = (task_trig | sw_task) & mdg_pkg::SENSE_MASK;
        next_st.outv = (next_st.outv | (trig & set_m)) & ~(trig & clr_m);
        next_st.outv = next_st.outv ^ (trig & tgl_m);

        // A new edge wins over a clear arriving in the same cycle
        next_st.evt       = (st.evt & ~evt_clr) | edge_hit;
        next_st.pin_event = edge_hit;
        next_st.irq       = |(next_st.evt & next_st.inten);
        next_st.wake      = |(next_st.evt & mdg_pkg::SENSE_MASK);

        next_st.pad       = pad_c;
        next_st.periph_in = st.sync2 & pad_c.ie;
        next_st.analog    = func_analog_m & mdg_pkg::ANALOG_MASK;
        next_st.xtal      = &(~(func_special_m ^ mdg_pkg::XTAL_MASK) | ~mdg_pkg::XTAL_MASK);
        next_st.ant       = &(~(func_special_m ^ mdg_pkg::ANT_MASK) | ~mdg_pkg::ANT_MASK);
        next_st.vref      = |(func_special_m & mdg_pkg::REF_MASK);
        next_st.hresp     = 1'b0;
    end

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st           <= '0;
            st.hreadyout <= 1'b1;
            for (int i = 0; i < 31; i++) begin
                st.cfg[i] <= mdg_pkg::ANT_MASK[i] ? mdg_pkg::CFG_ANT_RESET : mdg_pkg::CFG_RESET;
            end
            st.ant <= 1'b1;
        end else begin
            st <= next_st;
        end
    end

    assign hreadyout             = st.hreadyout;
    assign hrdata                = st.hrdata;
    assign hresp                 = st.hresp;
    assign pad                   = st.pad;
    assign periph_in             = st.periph_in;
    assign pin_event             = st.pin_event;
    assign analog_connect        = st.analog;
    assign lf_xtal_connect       = st.xtal;
    assign antenna_connect       = st.ant;
    assign converter_ref_connect = st.vref;
    assign wake_req              = st.wake;
    assign irq                   = st.irq;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    AST_ANALOG_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (func_analog_m & ~mdg_pkg::ANALOG_MASK) == 31'h0)
        else $error("analog function on a non-analog pin");

    AST_FAST_NO_SENSE: assert property (@(posedge hclk) disable iff (!hresetn)
        ((st.evt | st.pin_event) & mdg_pkg::FAST_MASK) == 31'h0)
        else $error("fast port raised an event");

    AST_HD_FAST_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        (pad.hd & ~mdg_pkg::FAST_MASK) == 31'h0)
        else $error("high drive on a slow port pin");

    AST_DISC_OFF: assert property (@(posedge hclk) disable iff (!hresetn)
        disc_m != 31'h0 |=> ((pad.oe | pad.ie) & $past(disc_m)) == 31'h0)
        else $error("disconnected pin has a buffer on");

    AST_OD_NO_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        od_out_m != 31'h0 |=> (pad.oe & pad.o & $past(od_out_m)) == 31'h0)
        else $error("open drain pin drove high");

    AST_PULL_EXCL: assert property (@(posedge hclk) disable iff (!hresetn)
        (pad.pu & pad.pd) == 31'h0)
        else $error("pull-up and pull-down together");

    AST_IRQ_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
        edge_hit != 31'h0 && (edge_hit & st.inten) != 31'h0 |=> irq && st.evt != 31'h0)
        else $error("enabled edge did not raise interrupt");

    AST_XDOM_FAST: assert property (@(posedge hclk) disable iff (!hresetn)
        (func_xdom_m & ~mdg_pkg::FAST_MASK) == 31'h0)
        else $error("cross-domain function off the fast port");

    AST_SPECIAL_PINS: assert property (@(posedge hclk) disable iff (!hresetn)
        (func_special_m & ~mdg_pkg::SPECIAL_MASK) == 31'h0 ##1 lf_xtal_connect == $past(&func_special_m[6:5]))
        else $error("crystal connect does not follow config");

    AST_WAKE_SLOW: assert property (@(posedge hclk) disable iff (!hresetn)
        wake_req |-> (st.evt & mdg_pkg::SENSE_MASK) != 31'h0)
        else $error("wake without a pending slow-port event");

    AST_TASK_SET: assert property (@(posedge hclk) disable iff (!hresetn)
        (task_trig & set_m & mdg_pkg::SENSE_MASK) != 31'h0 |=>
        (st.outv & $past(task_trig & set_m & mdg_pkg::SENSE_MASK)) == $past(task_trig & set_m & mdg_pkg::SENSE_MASK))
        else $error("set task did not raise output");

    AST_READ_WAIT: assert property (@(posedge hclk) disable iff (!hresetn)
        hsel && hready && htrans[1] && !hwrite |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");

    // Antenna and reference connects follow the config one cycle late
    AST_ANT_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> antenna_connect == $past(&func_special_m[8:7]))
        else $error("antenna connect does not follow config");

    AST_REF_FOLLOWS: assert property (@(posedge hclk) disable iff (!hresetn)
        1'b1 |=> converter_ref_connect == $past(func_special_m[13]))
        else $error("reference connect does not follow config");

    AST_TASK_CLR: assert property (@(posedge hclk) disable iff (!hresetn)
        (trig & clr_m) != 31'h0 |=>
        (st.outv & $past(trig & clr_m)) == 31'h0)
        else $error("clear task did not lower output");

    AST_IN_GATED: assert property (@(posedge hclk) disable iff (!hresetn)
        (periph_in & ~pad.ie) == 31'h0)
        else $error("input passed a closed buffer");

    AST_HRESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == 1'b0)
        else $error("bus response not okay");

endmodule : mdg_gpio
`default_nettype wire

// *** tb/mdg_pins_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module mdg_pins_model (
    input  wire mdg_pkg::mdg_pad_s pad,
    input  wire logic [30:0]       ext_level,
    input  wire logic [30:0]       ext_en,
    output logic [30:0]            pin_i
);
    // ------------------------------------------------------------------
    // Pad wire level
    // ------------------------------------------------------------------
    // A floating pin reads the inverse of the idle stimulus, so no stale level passes
    always_comb begin
        for (int i = 0; i < 31; i++) begin
            if (pad.oe[i]) begin
                pin_i[i] = pad.o[i];
            end else if (ext_en[i]) begin
                pin_i[i] = ext_level[i];
            end else if (pad.pu[i]) begin
                pin_i[i] = 1'b1;
            end else if (pad.pd[i]) begin
                pin_i[i] = 1'b0;
            end else begin
                pin_i[i] = ~ext_level[i];
            end
        end
    end
endmodule : mdg_pins_model
`default_nettype wire

// *** tb/multi_domain_gpio_ports_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module multi_domain_gpio_ports_bench;
    logic              hclk, hresetn, hsel, hwrite, hreadyout, rdy_n, lf, ant, cref, wake, irq, hresp;
    logic [1:0]        htrans;
    logic [31:0]       haddr, hwdata, hrdata, hrd_n, q, r;
    logic [30:0]       task_trig, ext_level, ext_en, pin_i, analog, pevt, pinv, xo;
    mdg_pkg::mdg_pad_s pad;
    int                miscompares, samples_checked, n;

    initial begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end
    // Values that stood at the coming rising edge
    always @(negedge hclk) begin
        rdy_n = hreadyout;
        hrd_n = hrdata;
    end

    mdg_gpio mdg_gpio_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hrdata(hrdata), .hresp(hresp), .pin_i(pin_i), .pad(pad), .periph_own_o(31'h0), .periph_own_oe(31'h0),
        .periph_xdom_o(xo), .periph_xdom_oe(xo), .task_trig(task_trig), .periph_in(pinv), .pin_event(pevt),
        .analog_connect(analog), .lf_xtal_connect(lf), .antenna_connect(ant), .converter_ref_connect(cref),
        .wake_req(wake), .irq(irq));
    mdg_pins_model mdg_pins_model_i (.pad(pad), .ext_level(ext_level), .ext_en(ext_en), .pin_i(pin_i));

    function automatic logic [31:0] cw(input logic [2:0] f, input logic [1:0] t, s, input logic [5:0] lo);
        return {13'h0, f, 2'h0, t, 2'h0, s, 2'h0, lo};
    endfunction : cw

    task automatic close_out;
        $display("checks %0d mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : close_out

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic tick(inout int k);
        @(posedge hclk);
        k++;
        if (k > 60) begin
            miscompares++;
            $display("wrong value at %0t: wait timed out", $time);
            close_out();
        end
    endtask : tick

    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        int k;
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {20'h0, a};
        hwrite <= w;
        k = 0;
        do tick(k); while (rdy_n !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        k = 0;
        do tick(k); while (rdy_n !== 1'b1);
        q = hrd_n;
    endtask : xfer

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask : wr

    task automatic rc(input logic [11:0] a, input logic [31:0] exp, input string m);
        xfer(1'b0, a, 32'h0);
        chk(q, exp, m);
    endtask : rc

    initial begin
        hresetn = 1'b0;
        {hsel, hwrite, htrans, haddr, hwdata, task_trig, ext_level, ext_en, xo} = '0;
        miscompares = 0;
        samples_checked = 0;
        r = $urandom(32'h3090b227);
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        // ------------------------------------------------------------------
        // Scenarios
        // ------------------------------------------------------------------
        chk({28'h0, hresp, ant, lf, cref}, 32'h4, "special pins at reset");
        chk({1'b0, pad.oe | pad.ie}, 32'h0, "buffers at reset");
        rc(12'h000, 32'h2, "cfg pin 0");
        rc(12'h01c, 32'h40002, "cfg antenna pin");
        rc(12'h0fc, 32'h0, "unmapped");
        $display("test reset done");
        wr(12'h000, cw(3'h3, 2'h0, 2'h0, 6'h0));
        rc(12'h000, 32'h0, "analog on plain pin");
        wr(12'h024, cw(3'h3, 2'h0, 2'h0, 6'h0));
        rc(12'h024, cw(3'h3, 2'h0, 2'h0, 6'h0), "analog pin");
        chk({1'b0, analog}, 32'h200, "analog connect");
        wr(12'h014, cw(3'h4, 2'h0, 2'h0, 6'h2));
        wr(12'h018, cw(3'h4, 2'h0, 2'h0, 6'h2));
        wr(12'h034, cw(3'h4, 2'h0, 2'h0, 6'h2));
        wr(12'h01c, 32'h2);
        rc(12'h01c, 32'h2, "antenna pin as io");
        chk({29'h0, ant, lf, cref}, 32'h3, "special connects");
        wr(12'h000, cw(3'h0, 2'h0, 2'h0, 6'h20));
        rc(12'h000, 32'h0, "drive on slow pin");
        wr(12'h050, cw(3'h0, 2'h0, 2'h0, 6'h21));
        rc(12'h050, 32'h21, "drive on fast pin");
        chk({31'h0, pad.hd[20]}, 32'h1, "fast pin drive");
        wr(12'h058, cw(3'h2, 2'h0, 2'h0, 6'h0));
        xo[22] <= 1'b1;
        rc(12'h058, 32'h20000, "shared pin cfg");
        chk({30'h0, pad.oe[22], pad.o[22]}, 32'h3, "shared pin routed");
        wr(12'h004, cw(3'h0, 2'h0, 2'h0, 6'h0c));
        repeat (2) @(posedge hclk);
        chk({30'h0, pad.pu[1], pad.pd[1]}, 32'h2, "pull up");
        wr(12'h004, cw(3'h0, 2'h0, 2'h0, 6'h04));
        rc(12'h004, 32'h4, "pull down cfg");
        chk({30'h0, pad.pu[1], pad.pd[1]}, 32'h1, "pull down");
        $display("test pin setup done");
        r[31] = 1'b0;
        r[8] = r[7];
        wr(mdg_pkg::OUT_OFS, r);
        rc(mdg_pkg::OUT_OFS, r, "random out");
        wr(12'h054, cw(3'h0, 2'h0, 2'h0, 6'h11));
        wr(mdg_pkg::OUTCLR_OFS, 32'h200000);
        r[21] = 1'b0;
        rc(mdg_pkg::OUT_OFS, r, "out clear");
        chk({30'h0, pad.oe[21], pad.o[21]}, 32'h2, "open drain low");
        wr(mdg_pkg::OUTSET_OFS, 32'h200000);
        r[21] = 1'b1;
        rc(mdg_pkg::OUT_OFS, r, "out set");
        chk({31'h0, pad.oe[21]}, 32'h0, "open drain released");
        wr(12'h00c, cw(3'h0, 2'h3, 2'h0, 6'h1));
        task_trig[3] <= 1'b1;
        @(posedge hclk);
        task_trig[3] <= 1'b0;
        r[3] = ~r[3];
        rc(mdg_pkg::OUT_OFS, r, "toggle on event");
        chk({31'h0, pad.o[3]}, {31'h0, r[3]}, "toggled pad");
        wr(mdg_pkg::TASK_OFS, 32'h8);
        r[3] = ~r[3];
        rc(mdg_pkg::OUT_OFS, r, "toggle by write");
        wr(12'h010, cw(3'h0, 2'h1, 2'h0, 6'h1));
        task_trig[4] <= 1'b1;
        @(posedge hclk);
        task_trig[4] <= 1'b0;
        r[4] = 1'b1;
        rc(mdg_pkg::OUT_OFS, r, "set on event");
        wr(12'h010, cw(3'h0, 2'h2, 2'h0, 6'h1));
        wr(mdg_pkg::TASK_OFS, 32'h10);
        r[4] = 1'b0;
        rc(mdg_pkg::OUT_OFS, r, "clear by write");
        wr(12'h060, cw(3'h0, 2'h3, 2'h1, 6'h0));
        rc(12'h060, 32'h0, "no hooks on fast pin");
        $display("test outputs done");
        wr(12'h008, cw(3'h0, 2'h0, 2'h1, 6'h0));
        wr(mdg_pkg::INTEN_OFS, 32'h4);
        ext_en[2] <= 1'b1;
        rc(mdg_pkg::EVT_OFS, 32'h0, "no event yet");
        ext_level[2] <= 1'b1;
        n = 0;
        while (irq !== 1'b1) tick(n);
        chk({28'h0, irq, wake, pevt[2], pinv[2]}, 32'hf, "edge raises irq and wake");
        rc(mdg_pkg::EVT_OFS, 32'h4, "sticky event");
        wr(mdg_pkg::EVTCLR_OFS, 32'h4);
        rc(mdg_pkg::EVT_OFS, 32'h0, "event cleared");
        chk({31'h0, irq}, 32'h0, "irq dropped");
        wr(12'h008, cw(3'h0, 2'h0, 2'h2, 6'h0));
        ext_level[2] <= 1'b0;
        n = 0;
        while (irq !== 1'b1) tick(n);
        rc(mdg_pkg::EVT_OFS, 32'h4, "falling edge");
        $display("test edge detect done");
        close_out();
    end
endmodule : multi_domain_gpio_ports_bench
`default_nettype wire
